// ==== board_pins.sv ====
// board model: the twelve pads seen from outside the block
// a pad the block does not drive is held by the board at boardVal
module board_pins
	import shared_pin_gpio_pkg::*;
(
	input wire pins_s pinOut, // block output levels
	input wire pins_s pinOeN, // block enables, low drives
	input wire pins_s boardVal, // levels the board applies
	output pins_s pinIn // resolved pad levels
);
	timeunit 1ns;
	timeprecision 1ns;
	// the board always drives released pads, so no pad floats to a stale value
	assign pinIn = (pinOut & ~pinOeN) | (boardVal & pinOeN);
endmodule

// ==== gpio_pin_chk.sv ====
// checker for shared_pin_gpio_ports: bus answer timing and pin ownership
// sees only top-level ports; bound to the block at the foot of this file
module gpio_pin_chk
	import shared_pin_gpio_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic nrst, // reset, active low
	input wire logic awvalid, // write address valid
	input wire logic awready, // write address ready
	input wire logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire logic bvalid, // write response valid
	input wire logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire logic rvalid, // read data valid
	input wire pins_s pinOeN, // pad enables, low drives
	input wire pins_s pullEn, // pull-up enables
	input wire logic [1:0] extIntIn, // interrupt levels
	input wire logic extResetN, // reset pin level
	input wire logic resetPinOpt, // reset-pin build option
	input wire hiclk_e hiClkOpt, // clock build option
	input wire logic oscInSel, // oscillator input taken
	input wire logic oscOutSel, // oscillator output taken
	input wire logic [4:0] analogSel, // adc channel pins
	input wire logic vrefSel // reference pin
);
	logic [2:0] relCnt; // edges since reset release, saturating
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	// options are latched after release, so wait before judging the selects
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			relCnt <= 3'h0;
		else if (relCnt != 3'h7)
			relCnt <= relCnt + 3'h1;
	end
	sequence rdTaken;
		arvalid && arready;
	endsequence
	sequence wrTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	// the $past terms allow one edge of skew between a select and its enable
	oe_a4_input_a: assert property (pinOeN.portA[4]) else $error("input-only pin driven");
	pull_a4_off_a: assert property (!pullEn.portA[4]) else $error("pull on input-only pin");
	pull_input_a: assert property ((pullEn[9:0] & ~pinOeN[9:0]) == 10'h000)
		else $error("pull-up on a driven pin");
	int_input_a: assert property ((pinOeN.portA[1:0] | $past(pinOeN.portA[1:0]) | extIntIn) == 2'h3)
		else $error("interrupt pin driven by gpio");
	reset_pin_a: assert property (!extResetN |-> resetPinOpt) else $error("reset without option");
	osc_sel_a: assert property (relCnt == 3'h7 |->
		oscInSel == (hiClkOpt inside {CLK_RC, CLK_32K, CLK_4M, CLK_12M}) &&
		oscOutSel == (hiClkOpt inside {CLK_32K, CLK_4M, CLK_12M})) else $error("oscillator select");
	vref_excl_a: assert property (vrefSel |-> !analogSel[0]) else $error("vref with channel 0");
	analog_one_a: assert property ($onehot0(analogSel)) else $error("several adc pins");
	analog_in_a: assert property (((analogSel | {4'h0, vrefSel}) & ~pinOeN.portB
		& ~$past(pinOeN.portB)) == 5'h00) else $error("analog pin still driven");
	rd_answer_a: assert property (rdTaken |=> rvalid) else $error("late read answer");
	wr_answer_a: assert property (wrTaken |-> ##2 bvalid) else $error("late write answer");
endmodule

bind shared_pin_gpio_ports gpio_pin_chk chk_i (.*);

// ==== shared_pin_gpio_defs.svh ====
// register indices, field positions, reset values and bus codes of the shared-pin gpio block
// assumes the includer uses a 12-bit byte address where byte address = index * 4
`ifndef SHARED_PIN_GPIO_DEFS_SVH
`define SHARED_PIN_GPIO_DEFS_SVH

// register indices (byte address is four times the index)
`define IDX_DIR_A 10'h0B8
`define IDX_DIR_B 10'h0C4
`define IDX_DIR_C 10'h0C5
`define IDX_DATA_A 10'h0D0
`define IDX_DATA_B 10'h0D4
`define IDX_DATA_C 10'h0D5
`define IDX_PULL_A 10'h0E0
`define IDX_PULL_B 10'h0E4
`define IDX_PULL_C 10'h0E5
`define IDX_FUNC 10'h0F0
`define IDX_ADC 10'h0F1
`define IDX_BITOP 10'h0F2
`define IDX_STAT 10'h0F3

// function control register fields
`define FUNC_EXTERNAL_INTERRUPT_IN_0_EN 0
`define FUNC_EXTERNAL_INTERRUPT_IN_1_EN 1
`define FUNC_T0_EN 2
`define FUNC_T0_OUT 3
`define FUNC_TIMER0_PWM_OUTPUT_OUT 4
`define FUNC_T1_EN 5
`define FUNC_T1_OUT 6
`define FUNC_TIMER1_PWM_OUTPUT_OUT 7

// analog control register fields
`define ADC_EN 7
`define ADC_VREF_EN 6
`define ADC_GCH 4
`define ADC_CHS_HI 2
`define ADC_CHS_LO 0

// bit operation register fields
`define BITOP_VAL 7
`define BITOP_TGT_HI 5
`define BITOP_TGT_LO 3
`define BITOP_BIT_HI 2
`define BITOP_BIT_LO 0

// reset values
`define RST_REG8 8'h00

// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== shared_pin_gpio_pkg.sv ====
// types shared by the shared-pin gpio block and its bench
// assumes nothing beyond a SystemVerilog compiler
package shared_pin_gpio_pkg;

	// one bit per pin, grouped by port; port_c only has bits 4 and 3
	typedef struct packed {
		logic [4:3] portC;
		logic [4:0] portB;
		logic [4:0] portA;
	} pins_s;

	// high-clock build option
	typedef enum logic [2:0] {
		CLK_INTERNAL,
		CLK_RC,
		CLK_32K,
		CLK_4M,
		CLK_12M
	} hiclk_e;

	// targets of the single-bit operation register
	typedef enum logic [2:0] {
		TGT_DIR_A,
		TGT_DIR_B,
		TGT_DIR_C,
		TGT_DATA_A,
		TGT_DATA_B,
		TGT_DATA_C,
		TGT_NONE
	} bittgt_e;

endpackage

// ==== shared_pin_gpio_ports.sv ====
// twelve-pin gpio block with shared functions, reached over an AXI4-Lite slave
// assumes pins are resolved outside from out/oeN, and timer signals share core_clk
//
// Contract
// - twelve gpio pins over three ports, each one shared
// - port_a bits 0 and 1 become interrupt inputs
// - port_a bit 4 is reset input by option
// - port_a bit 3 is oscillator input for options
// - port_a bit 2 oscillator output, not for RC
// - port_c bit 3 carries timer1 pwm or buzzer
// - port_c bit 4 carries timer0 pwm or buzzer
// - port_b bit 0 is analog channel 0
// - port_b bit 0 takes the external reference
// - port_b bits 4..1 are analog channels 4..1
// - direction bit 0 input, 1 output, reset 0
// - port_a bit 4 input only, no direction
// - pull-up bit enables pull-up in input mode
// - port_a bit 4 has no pull-up bit
// - reset option makes port_a bit 4 read 1
// - single bits set or cleared without disturbing others
// - data read gives pins, write loads latch
// - reference enable removes gpio and channel 0
// - global channel off keeps port_b digital except bit 0, which the reference enable still takes
//
// Design decision made here: the AXI4-Lite slave port.
`include "shared_pin_gpio_defs.svh"

module shared_pin_gpio_ports
	import shared_pin_gpio_pkg::*;
(
	input wire logic core_clk, // system clock, 10 MHz
	input wire logic nrst, // asynchronous reset, active low
	input wire logic [11:0] awaddr, // write address
	input wire logic [2:0] awprot, // write protection, unused
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [11:0] araddr, // read address
	input wire logic [2:0] arprot, // read protection, unused
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire pins_s pinIn, // pin levels seen at the pads
	output pins_s pinOut, // pin output levels
	output pins_s pinOeN, // pin output enables, low drives
	output pins_s pullEn, // internal pull-up enables
	input wire logic resetPinOpt, // build option: port_a bit 4 is reset
	input wire hiclk_e hiClkOpt, // build option: high clock source
	input wire logic timer0Pwm, // timer 0 pwm from the timer
	input wire logic timer0Buzz, // timer 0 buzzer from the timer
	input wire logic timer1Pwm, // timer 1 pwm from the timer
	input wire logic timer1Buzz, // timer 1 buzzer from the timer
	output logic [1:0] extIntIn, // external interrupt levels, idle high
	output logic extResetN, // external reset level, active low
	output logic oscInSel, // port_a bit 3 given to oscillator input
	output logic oscOutSel, // port_a bit 2 given to oscillator output
	output logic [4:0] analogSel, // port_b pin given to adc channel n
	output logic vrefSel // port_b bit 0 given to the reference
);

	// software visible state
	logic [3:0] dirA_r; // port_a direction, bit 4 absent
	logic [4:0] dirB_r; // port_b direction
	logic [4:3] dirC_r; // port_c direction
	logic [3:0] latchA_r; // port_a output latch, bit 1 stays 0
	logic [4:0] latchB_r; // port_b output latch
	logic [4:3] latchC_r; // port_c output latch
	logic [3:0] pullA_r; // port_a pull-up bits
	logic [4:0] pullB_r; // port_b pull-up bits
	logic [4:3] pullC_r; // port_c pull-up bits
	logic [7:0] func_r; // shared function enables
	logic [7:0] adc_r; // analog routing controls

	// build options caught once after reset release
	logic strapDone_r;
	logic rstOpt_r;
	hiclk_e hiClk_r;

	// bus state
	logic [11:0] awAddr_r;
	logic [7:0] wByte_r;
	logic wLane0_r;
	logic commit;
	logic mapped;
	logic [9:0] wIdx;
	logic [9:0] rIdx;
	bittgt_e tgt;
	logic [7:0] tgtVal;
	logic [7:0] tgtCur;
	logic [7:0] rdVal;
	logic rdHit;

	// pin synchronisers
	logic [11:0] pinRaw;
	logic [11:0] sync1_r;
	logic [11:0] sync2_r;
	logic [11:0] sync3_r;
	logic [11:0] pinFilt_r;
	pins_s pinNow;

	// shared function decode
	logic int0En, int1En;
	logic pwm1On, buzz1On, pwm0On, buzz0On;
	logic adcOn, vrefOn;
	logic [2:0] chs;
	logic [4:0] anaNxt;
	logic oscInNxt, oscOutNxt;
	pins_s outNxt, oeNNxt, pullNxt;

	assign pinRaw = pinIn;
	assign pinNow = pinFilt_r;

	// three synchroniser flops and a filter flop per pin; a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 12; g = g + 1) begin : g_sync
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					// interrupt and reset pins start idle high, so no false low leaves after reset
					sync1_r[g] <= (g == 0 || g == 1 || g == 4);
					sync2_r[g] <= (g == 0 || g == 1 || g == 4);
					sync3_r[g] <= (g == 0 || g == 1 || g == 4);
					pinFilt_r[g] <= (g == 0 || g == 1 || g == 4);
				end else begin
					sync1_r[g] <= pinRaw[g];
					sync2_r[g] <= sync1_r[g];
					sync3_r[g] <= sync2_r[g];
					if (sync2_r[g] == sync3_r[g]) begin
						pinFilt_r[g] <= sync3_r[g];
					end
				end
			end
		end
	endgenerate

	// build options are static, so they are sampled on the first edge after release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			strapDone_r <= 1'b0;
			rstOpt_r <= 1'b0;
			hiClk_r <= CLK_INTERNAL;
		end else if (!strapDone_r) begin
			strapDone_r <= 1'b1;
			rstOpt_r <= resetPinOpt;
			hiClk_r <= hiClkOpt;
		end
	end

	// write address channel: taken once, released when the response is taken
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			awready <= 1'b1;
			awAddr_r <= 12'h000;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			awAddr_r <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	// write data channel: only byte lane 0 carries register bits
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wready <= 1'b1;
			wByte_r <= `RST_REG8;
			wLane0_r <= 1'b0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			wByte_r <= wdata[7:0];
			wLane0_r <= wstrb[0];
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// the write lands on the edge after both halves are held
	assign commit = !awready && !wready && !bvalid;
	assign wIdx = awAddr_r[11:2];
	assign rIdx = araddr[11:2];

	// write decode: direct writes and the single-bit operation share one target path
	always_comb begin
		tgt = TGT_NONE;
		tgtVal = wByte_r;
		tgtCur = `RST_REG8;
		mapped = 1'b1;
		if (wIdx == `IDX_DIR_A) begin
			tgt = TGT_DIR_A;
		end else if (wIdx == `IDX_DIR_B) begin
			tgt = TGT_DIR_B;
		end else if (wIdx == `IDX_DIR_C) begin
			tgt = TGT_DIR_C;
		end else if (wIdx == `IDX_DATA_A) begin
			tgt = TGT_DATA_A;
		end else if (wIdx == `IDX_DATA_B) begin
			tgt = TGT_DATA_B;
		end else if (wIdx == `IDX_DATA_C) begin
			tgt = TGT_DATA_C;
		end else if (wIdx == `IDX_BITOP) begin
			tgt = bittgt_e'(wByte_r[`BITOP_TGT_HI:`BITOP_TGT_LO]);
		end else if (wIdx == `IDX_PULL_A || wIdx == `IDX_PULL_B || wIdx == `IDX_PULL_C) begin
			tgt = TGT_NONE; // pull-ups have their own write path
		end else if (wIdx == `IDX_FUNC || wIdx == `IDX_ADC || wIdx == `IDX_STAT) begin
			tgt = TGT_NONE; // control handled below, status ignores writes
		end else begin
			mapped = 1'b0; // unmapped answers an error
		end
		// current value of the target, so a single bit can change alone
		case (tgt)
			TGT_DIR_A: tgtCur = {4'h0, dirA_r};
			TGT_DIR_B: tgtCur = {3'h0, dirB_r};
			TGT_DIR_C: tgtCur = {3'h0, dirC_r, 3'h0};
			TGT_DATA_A: tgtCur = {4'h0, latchA_r};
			TGT_DATA_B: tgtCur = {3'h0, latchB_r};
			TGT_DATA_C: tgtCur = {3'h0, latchC_r, 3'h0};
			default: tgtCur = `RST_REG8;
		endcase
		if (wIdx == `IDX_BITOP) begin
			if (wByte_r[`BITOP_VAL]) begin
				tgtVal = tgtCur | (8'h01 << wByte_r[`BITOP_BIT_HI:`BITOP_BIT_LO]);
			end else begin
				tgtVal = tgtCur & ~(8'h01 << wByte_r[`BITOP_BIT_HI:`BITOP_BIT_LO]);
			end
		end
	end

	// write response: error only for an unmapped address
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (commit) begin
			bvalid <= 1'b1;
			bresp <= mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// direction bits; port_a bit 4 has no flop at all
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dirA_r <= 4'h0;
			dirB_r <= 5'h00;
			dirC_r <= 2'h0;
		end else if (commit && wLane0_r) begin
			if (tgt == TGT_DIR_A) begin
				dirA_r <= tgtVal[3:0];
			end
			if (tgt == TGT_DIR_B) begin
				dirB_r <= tgtVal[4:0];
			end
			if (tgt == TGT_DIR_C) begin
				dirC_r <= tgtVal[4:3];
			end
		end
	end

	// output latches; port_a bit 1 is read-only and bit 4 input-only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			latchA_r <= 4'h0;
			latchB_r <= 5'h00;
			latchC_r <= 2'h0;
		end else if (commit && wLane0_r) begin
			if (tgt == TGT_DATA_A) begin
				latchA_r <= {tgtVal[3:2], 1'b0, tgtVal[0]};
			end
			if (tgt == TGT_DATA_B) begin
				latchB_r <= tgtVal[4:0];
			end
			if (tgt == TGT_DATA_C) begin
				latchC_r <= tgtVal[4:3];
			end
		end
	end

	// pull-up bits are write-only; port_a bit 4 has none
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pullA_r <= 4'h0;
			pullB_r <= 5'h00;
			pullC_r <= 2'h0;
		end else if (commit && wLane0_r) begin
			if (wIdx == `IDX_PULL_A) begin
				pullA_r <= wByte_r[3:0];
			end
			if (wIdx == `IDX_PULL_B) begin
				pullB_r <= wByte_r[4:0];
			end
			if (wIdx == `IDX_PULL_C) begin
				pullC_r <= wByte_r[4:3];
			end
		end
	end

	// shared function and analog routing controls
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			func_r <= `RST_REG8;
			adc_r <= `RST_REG8;
		end else if (commit && wLane0_r) begin
			if (wIdx == `IDX_FUNC) begin
				func_r <= wByte_r;
			end
			if (wIdx == `IDX_ADC) begin
				adc_r <= {wByte_r[7:6], 1'b0, wByte_r[4], 1'b0, wByte_r[2:0]};
			end
		end
	end

	// read decode; a read of the data registers sees the filtered pins
	always_comb begin
		rdVal = `RST_REG8;
		rdHit = 1'b1;
		if (rIdx == `IDX_DIR_A) begin
			rdVal = {4'h0, dirA_r};
		end else if (rIdx == `IDX_DIR_B) begin
			rdVal = {3'h0, dirB_r};
		end else if (rIdx == `IDX_DIR_C) begin
			rdVal = {3'h0, dirC_r, 3'h0};
		end else if (rIdx == `IDX_DATA_A) begin
			rdVal = {3'h0, rstOpt_r | pinNow.portA[4], pinNow.portA[3:0]};
		end else if (rIdx == `IDX_DATA_B) begin
			rdVal = {3'h0, pinNow.portB};
		end else if (rIdx == `IDX_DATA_C) begin
			rdVal = {3'h0, pinNow.portC, 3'h0};
		end else if (rIdx == `IDX_PULL_A || rIdx == `IDX_PULL_B || rIdx == `IDX_PULL_C) begin
			rdVal = `RST_REG8; // write-only, reads zero
		end else if (rIdx == `IDX_FUNC) begin
			rdVal = func_r;
		end else if (rIdx == `IDX_ADC) begin
			rdVal = adc_r;
		end else if (rIdx == `IDX_BITOP) begin
			rdVal = `RST_REG8;
		end else if (rIdx == `IDX_STAT) begin
			rdVal = {oscOutSel, oscInSel, vrefSel, analogSel}; // who holds which pin
		end else begin
			rdHit = 1'b0;
		end
	end

	// read channel: the answer is registered on the same edge that takes the address
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, rdVal};
			rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// shared function conditions
	assign int0En = func_r[`FUNC_EXTERNAL_INTERRUPT_IN_0_EN];
	assign int1En = func_r[`FUNC_EXTERNAL_INTERRUPT_IN_1_EN];
	assign pwm1On = func_r[`FUNC_T1_EN] && func_r[`FUNC_TIMER1_PWM_OUTPUT_OUT];
	assign buzz1On = func_r[`FUNC_T1_EN] && func_r[`FUNC_T1_OUT] && !func_r[`FUNC_TIMER1_PWM_OUTPUT_OUT];
	assign pwm0On = func_r[`FUNC_T0_EN] && func_r[`FUNC_TIMER0_PWM_OUTPUT_OUT];
	assign buzz0On = func_r[`FUNC_T0_EN] && func_r[`FUNC_T0_OUT] && !func_r[`FUNC_TIMER0_PWM_OUTPUT_OUT];
	assign adcOn = adc_r[`ADC_EN] && adc_r[`ADC_GCH];
	assign vrefOn = adc_r[`ADC_VREF_EN];
	assign chs = adc_r[`ADC_CHS_HI:`ADC_CHS_LO];
	// channel codes 101 to 111 give no port_b pin to an adc channel

	// port_b channel decode; the reference enable removes channel 0
	always_comb begin
		anaNxt = 5'h00;
		if (adcOn && chs <= 3'h4) begin
			anaNxt[chs] = 1'b1;
		end
		if (vrefOn) begin
			anaNxt[0] = 1'b0;
		end
	end

	// oscillator pins follow the high-clock build option
	assign oscInNxt = (hiClk_r != CLK_INTERNAL);
	assign oscOutNxt = (hiClk_r == CLK_32K) || (hiClk_r == CLK_4M) || (hiClk_r == CLK_12M);

	// pin drive: gpio first, then each active shared function overrides it
	always_comb begin
		outNxt = '0;
		oeNNxt = '1;
		pullNxt = '0;
		outNxt.portA[3:0] = latchA_r;
		oeNNxt.portA[3:0] = ~dirA_r;
		pullNxt.portA[3:0] = pullA_r & ~dirA_r;
		outNxt.portB = latchB_r;
		oeNNxt.portB = ~dirB_r;
		pullNxt.portB = pullB_r & ~dirB_r;
		outNxt.portC = latchC_r;
		oeNNxt.portC = ~dirC_r;
		pullNxt.portC = pullC_r & ~dirC_r;
		// interrupt inputs force input mode but keep the pull-up usable
		if (int0En) begin
			oeNNxt.portA[0] = 1'b1;
			pullNxt.portA[0] = pullA_r[0];
		end
		if (int1En) begin
			oeNNxt.portA[1] = 1'b1;
			pullNxt.portA[1] = pullA_r[1];
		end
		// oscillator pins are analog: no digital drive, no pull-up
		if (oscOutNxt) begin
			oeNNxt.portA[2] = 1'b1;
			pullNxt.portA[2] = 1'b0;
		end
		if (oscInNxt) begin
			oeNNxt.portA[3] = 1'b1;
			pullNxt.portA[3] = 1'b0;
		end
		// analog channel pins and the reference pin drop their digital path
		for (int i = 0; i < 5; i = i + 1) begin
			if (anaNxt[i]) begin
				oeNNxt.portB[i] = 1'b1;
				pullNxt.portB[i] = 1'b0;
			end
		end
		if (vrefOn) begin
			oeNNxt.portB[0] = 1'b1;
			pullNxt.portB[0] = 1'b0;
		end
		// timer outputs drive regardless of the direction bit
		if (pwm1On || buzz1On) begin
			outNxt.portC[3] = pwm1On ? timer1Pwm : timer1Buzz;
			oeNNxt.portC[3] = 1'b0;
			pullNxt.portC[3] = 1'b0;
		end
		if (pwm0On || buzz0On) begin
			outNxt.portC[4] = pwm0On ? timer0Pwm : timer0Buzz;
			oeNNxt.portC[4] = 1'b0;
			pullNxt.portC[4] = 1'b0;
		end
	end

	// all pad-facing outputs are registered to keep glitches off the pins
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pinOut <= '0;
			pinOeN <= '1;
			pullEn <= '0;
			analogSel <= 5'h00;
			vrefSel <= 1'b0;
			oscInSel <= 1'b0;
			oscOutSel <= 1'b0;
		end else begin
			pinOut <= outNxt;
			pinOeN <= oeNNxt;
			pullEn <= pullNxt;
			analogSel <= anaNxt;
			vrefSel <= adc_r[`ADC_EN] && vrefOn;
			oscInSel <= oscInNxt;
			oscOutSel <= oscOutNxt;
		end
	end

	// interrupt and reset levels; idle high when the pin is not given over
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			extIntIn <= 2'h3;
			extResetN <= 1'b1;
		end else begin
			extIntIn[0] <= int0En ? pinNow.portA[0] : 1'b1;
			extIntIn[1] <= int1En ? pinNow.portA[1] : 1'b1;
			extResetN <= rstOpt_r ? pinNow.portA[4] : 1'b1;
		end
	end

endmodule

// ==== shared_pin_gpio_ports_tb.sv ====
// self-checking bench for shared_pin_gpio_ports with a board model
// assumes a 10 MHz core_clk; build options change only while reset is held
`include "shared_pin_gpio_defs.svh"
module shared_pin_gpio_ports_tb;
	import shared_pin_gpio_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0; // system clock
	logic nrst = 1'b0; // reset, active low
	logic [11:0] awaddr = 12'h000, araddr = 12'h000; // byte addresses
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata; // bus data
	logic [3:0] wstrb = 4'h0, tmr = 4'h0; // strobes; timer signals
	logic awready, wready, bvalid, arready, rvalid, extResetN, oscInSel, oscOutSel, vrefSel;
	logic [1:0] bresp, rresp, extIntIn;
	logic [4:0] analogSel;
	pins_s pinIn, pinOut, pinOeN, pullEn;
	pins_s boardVal = 12'h000; // board levels
	logic [31:0] seed = 32'h0000B827; // xorshift state
	int n_mismatch = 0, comparisons = 0;
	// model: register images, then expected pin state
	logic [7:0] rg [0:12];
	logic [9:0] idx [0:12] = '{`IDX_DIR_A, `IDX_DIR_B, `IDX_DIR_C, `IDX_DATA_A, `IDX_DATA_B,
		`IDX_DATA_C, `IDX_PULL_A, `IDX_PULL_B, `IDX_PULL_C, `IDX_FUNC, `IDX_ADC, `IDX_BITOP, `IDX_STAT};
	logic [7:0] wm [0:12] = '{8'h0F, 8'h1F, 8'h18, 8'h0D, 8'h1F, 8'h18, 8'h0F, 8'h1F, 8'h18,
		8'hFF, 8'hD7, 8'h00, 8'h00}; // writable bits
	logic [11:0] oeX, outX, puX, cm, lv; // expected enables, outputs, pulls, mask, levels
	logic [4:0] asX;
	logic vrX;
	logic [1:0] osX; // expected oscillator selects, input then output
	hiclk_e hiOpt = CLK_INTERNAL; // high clock build option
	logic rOpt = 1'b1; // reset-pin build option

	always #50 core_clk = ~core_clk;

	shared_pin_gpio_ports dut (.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
		.pullEn(pullEn), .resetPinOpt(rOpt), .hiClkOpt(hiOpt), .timer0Pwm(tmr[1]),
		.timer0Buzz(tmr[0]), .timer1Pwm(tmr[3]), .timer1Buzz(tmr[2]), .extIntIn(extIntIn),
		.extResetN(extResetN), .oscInSel(oscInSel), .oscOutSel(oscOutSel),
		.analogSel(analogSel), .vrefSel(vrefSel));
	board_pins board (.pinOut(pinOut), .pinOeN(pinOeN), .boardVal(boardVal), .pinIn(pinIn));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic final_report;
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic hang;
		n_mismatch++;
		final_report;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// write: address and data together, bready up until the answer
	task automatic wr(input logic [9:0] ix, input logic [7:0] v, input logic [3:0] st,
		input logic [1:0] er);
		int n;
		@(posedge core_clk);
		awaddr <= {ix, 2'h0};
		wdata <= {24'h0, v};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !(bvalid && bready); n++) begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bresp", bresp, er);
		if (n == 50) hang;
	endtask

	task automatic rd(input logic [9:0] ix, output logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge core_clk);
		araddr <= {ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !(rvalid && rready); n++) begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 50) hang;
	endtask

	// expected pin state from register images, timers and board levels
	task automatic model;
		logic [11:0] dir, pu;
		int c;
		dir = {rg[2][4:3], rg[1][4:0], rg[0][4:0]};
		pu = {rg[8][4:3], rg[7][4:0], rg[6][4:0]};
		oeX = ~dir;
		outX = {rg[5][4:3], rg[4][4:0], rg[3][4:0]};
		puX = pu & ~dir;
		cm = 12'hFFF;
		asX = 5'h00;
		vrX = rg[10][7] & rg[10][6];
		c = rg[10][2:0];
		for (int i = 0; i < 2; i++) begin
			if (rg[9][i]) begin
				oeX[i] = 1'b1;
				puX[i] = pu[i];
			end
		end
		// oscillator pins lose their digital driver and pull-up
		osX = {hiOpt != CLK_INTERNAL, hiOpt inside {CLK_32K, CLK_4M, CLK_12M}};
		if (osX[1]) {oeX[3], puX[3]} = 2'h2;
		if (osX[0]) {oeX[2], puX[2]} = 2'h2;
		for (int t = 0; t < 2; t++) begin
			if (rg[9][2 + 3 * t] && (rg[9][3 + 3 * t] || rg[9][4 + 3 * t])) begin
				oeX[11 - t] = 1'b0;
				outX[11 - t] = rg[9][4 + 3 * t] ? tmr[2 * t + 1] : tmr[2 * t];
			end
		end
		if (rg[10][6]) begin
			oeX[5] = 1'b0 | 1'b1;
			cm[5] = 1'b0;
		end
		if (rg[10][7] && rg[10][4] && c < 5 && !(c == 0 && rg[10][6])) begin
			asX[c] = 1'b1;
			oeX[5 + c] = 1'b1;
			cm[5 + c] = 1'b0;
		end
		lv = (outX & ~oeX) | (boardVal & oeX);
	endtask

	function automatic logic [31:0] exp_rd(input int k);
		case (k)
			0, 1, 2, 9, 10: return {24'h0, rg[k]};
			3: return {27'h0, rOpt | lv[4], lv[3:0]};
			4: return {27'h0, lv[9:5]};
			5: return {27'h0, lv[11:10], 3'h0};
			12: return {24'h0, osX[0], osX[1], vrX, asX};
			default: return 32'h0;
		endcase
	endfunction

	// compare pads and every register after the synchronisers settle
	task automatic check_all;
		logic [31:0] d, m;
		logic [1:0] rs;
		model;
		repeat (6) @(posedge core_clk);
		chk("oe", pinOeN, oeX);
		chk("out", pinOut & ~oeX, outX & ~oeX);
		chk("pull", pullEn & cm & oeX, puX & cm & oeX);
		chk("int", extIntIn, {rg[9][1] ? lv[1] : 1'b1, rg[9][0] ? lv[0] : 1'b1});
		chk("rst", extResetN, rOpt ? lv[4] : 1'b1);
		chk("ain", {vrefSel, analogSel}, {vrX, asX});
		chk("osc", {oscInSel, oscOutSel}, osX);
		for (int k = 0; k < 13; k++) begin
			m = (k == 4) ? {27'h0, cm[9:5]} : 32'hFFFFFFFF;
			rd(idx[k], d, rs);
			chk("rdata", d & m, exp_rd(k) & m);
			chk("rresp", rs, `RESP_OKAY);
		end
	endtask

	task automatic do_reset;
		nrst <= 1'b0;
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		foreach (rg[k]) rg[k] = 8'h00;
	endtask

	// random writes, strobe-less writes and single-bit operations
	initial begin
		logic [31:0] r, d;
		logic [1:0] rs;
		int k, t;
		do_reset;
		check_all;
		for (int it = 0; it < 40; it++) begin
			r = xs();
			tmr <= r[3:0];
			boardVal <= r[15:4];
			k = int'(r[31:28]) % 12;
			t = r[21:19];
			wr(idx[k], r[23:16], r[24] ? 4'hF : 4'hE, `RESP_OKAY);
			if (r[24] && k == 11 && t < 6 && wm[t][r[18:16]])
				rg[t][r[18:16]] = r[23];
			else if (r[24] && k != 11)
				rg[k] = r[23:16] & wm[k];
			// options change only across a reset, as a build option would
			if (it == 20 || it == 30) begin
				hiOpt <= (it == 20) ? CLK_RC : CLK_12M;
				rOpt <= (it == 30);
				do_reset;
			end
			check_all;
		end
		wr(10'h0F4, 8'hFF, 4'hF, `RESP_SLVERR);
		rd(10'h0F4, d, rs);
		chk("umap data", d, 32'h0);
		chk("umap resp", rs, `RESP_SLVERR);
		check_all;
		final_report;
	end
endmodule
